//--- pmt_pkg.sv
// Constants and types shared by the PMBus telemetry and status block
package pmt_pkg;

	// ==========================================================
	// Bus address and command codes
	localparam logic [6:0] BUS_ADDR          = 7'h10;
	localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS   = 8'h7A;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS   = 8'h7B;
	localparam logic [7:0] CMD_STATUS_INPUT  = 8'h7C;
	localparam logic [7:0] CMD_STATUS_TEMP   = 8'h7D;
	localparam logic [7:0] CMD_STATUS_COMM   = 8'h7E;
	localparam logic [7:0] CMD_READ_VIN      = 8'h88;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_READING     = 8'h8C;
	localparam logic [7:0] CMD_READ_TEMP     = 8'h8D;
	localparam logic [7:0] CMD_VIN_OFFSET    = 8'hD0;
	localparam logic [7:0] CMD_VIN_GAIN      = 8'hD1;
	localparam logic [7:0] CMD_IOUT_OFFSET   = 8'hD2;
	localparam logic [7:0] CMD_IOUT_GAIN     = 8'hD3;

	// ==========================================================
	// Linear format and corrections
	localparam logic [4:0]         EXP_VIN         = 5'h1D;
	localparam logic [4:0]         EXP_IOUT        = 5'h1C;
	localparam logic [4:0]         EXP_TEMP        = 5'h1E;
	localparam int                 GAIN_SHIFT      = 13;
	localparam int                 IOUT_LSB_UA     = 62500;
	localparam int                 IOUT_BLANK_UA   = 1650000;
	localparam logic signed [17:0] IOUT_BLANK_CNT  =
		18'((IOUT_BLANK_UA + IOUT_LSB_UA - 1) / IOUT_LSB_UA);
	localparam logic signed [17:0] MANT_MAX_S      = 18'h003FF;
	localparam logic [10:0]        MANT_MAX        = 11'h3FF;
	localparam logic [10:0]        MANT_ZERO       = 11'h000;
	localparam logic signed [11:0] TEMP_REF_CNT    = 12'h064;
	localparam int                 TC_SHIFT        = 8;

	// ==========================================================
	// Latched flag indices
	localparam int FLG_VOUT_OV   = 0;
	localparam int FLG_IOUT_OC   = 1;
	localparam int FLG_IOUT_WARN = 2;
	localparam int FLG_VIN_OV    = 3;
	localparam int FLG_VIN_UV    = 4;
	localparam int FLG_VIN_OFF   = 5;
	localparam int FLG_OT        = 6;
	localparam int FLG_OT_WARN   = 7;
	localparam int FLG_CML_CMD   = 8;
	localparam int FLG_CML_DATA  = 9;
	localparam int FLG_CML_PEC   = 10;
	localparam int NUM_FLAGS     = 11;

	// ==========================================================
	// Status bit positions
	localparam int STW_VOUT    = 15;
	localparam int STW_IOUT    = 14;
	localparam int STW_INPUT   = 13;
	localparam int STW_PG_N    = 11;
	localparam int STW_OFF     = 6;
	localparam int STW_VOUT_OV = 5;
	localparam int STW_IOUT_OC = 4;
	localparam int STW_VIN_UV  = 3;
	localparam int STW_TEMP    = 2;
	localparam int STW_CML     = 1;
	localparam int BIT_FAULT   = 7;
	localparam int BIT_IO_WARN = 5;
	localparam int BIT_IN_UV   = 4;
	localparam int BIT_IN_OFF  = 3;
	localparam int BIT_OT_WARN = 6;
	localparam int BIT_CML_DAT = 6;
	localparam int BIT_CML_PEC = 5;
	localparam logic [15:0] STATUS_WORD_RST = 16'h0000;
	localparam logic [7:0]  STATUS_BYTE_RST = 8'h00;

	// ==========================================================
	// Packet error check and idle data
	localparam logic [7:0] CRC_POLY  = 8'h07;
	localparam logic [7:0] CRC_INIT  = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;

	// ==========================================================
	// Types
	typedef struct packed {
		logic vout_ov;
		logic iout_oc;
		logic iout_oc_warn;
		logic vin_ov;
		logic vin_uv;
		logic vin_low_off;
		logic ot;
		logic ot_warn;
		logic unit_off;
		logic power_good;
	} pmt_cond_type;

	typedef struct packed {
		logic [10:0] vin_offset;
		logic [15:0] vin_gain;
		logic [10:0] iout_offset;
		logic [15:0] iout_gain;
	} pmt_cal_type;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_TXLOAD
	} pmt_state_type;

endpackage

//--- pmt_telemetry_status.sv
// PMBus telemetry encoding, status flags and bus slave
//
// Functional notes
// - Input voltage word, exponent -3, positive mantissa
// - Input voltage offset readable, exponent -3
// - Input voltage uses factory gain and offset
// - Output current word, exponent -4, positive mantissa
// - Current below 1.65A reads zero
// - Output current offset readable, exponent -4
// - Current is raw times gain/8192 plus offset
// - Sinking current reads zero
// - Current reading is temperature compensated
// - Temperature word, exponent -2, signed mantissa
// - Status word high byte summary bits
// - Status word low byte summary bits
// - Output voltage status holds only overvoltage
// - Output current status fault and warning
// - Input status overvoltage, undervoltage, low-input off
// - Temperature status fault and warning
// - Communication status command, data, check errors
// - Unsupported bits zero; all flags reset zero
`timescale 1ns/1ns
module pmt_telemetry_status
	import pmt_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe_n,
	input  wire logic        [10:0] vin_adc,
	input  wire logic signed [10:0] iout_adc,
	input  wire logic signed [10:0] temp_adc,
	input  wire pmt_cal_type        cal,
	input  wire pmt_cond_type       cond
);

	// ==========================================================
	// Packet error check
	function automatic logic [7:0] crc8_step(input logic [7:0] crc_in, input logic [7:0] data);
		logic [7:0] c;
		c = crc_in ^ data;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction

	function automatic logic is_word_cmd(input logic [7:0] c);
		return (c == CMD_STATUS_WORD) || (c == CMD_READ_VIN) || (c == CMD_OUTPUT_CURRENT_READING) ||
			(c == CMD_READ_TEMP) || (c == CMD_VIN_OFFSET) || (c == CMD_VIN_GAIN) ||
			(c == CMD_IOUT_OFFSET) || (c == CMD_IOUT_GAIN);
	endfunction

	function automatic logic is_byte_cmd(input logic [7:0] c);
		return (c == CMD_OUTPUT_VOLTAGE_STATUS) || (c == CMD_OUTPUT_CURRENT_STATUS) || (c == CMD_STATUS_INPUT) ||
			(c == CMD_STATUS_TEMP) || (c == CMD_STATUS_COMM);
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic scl_meta;
	logic scl_sync;
	logic scl_prev;
	logic sda_meta;
	logic sda_sync;
	logic sda_prev;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_meta <= scl_in;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	wire scl_rise  = scl_sync & ~scl_prev;
	wire scl_fall  = ~scl_sync & scl_prev;
	wire bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
	wire bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// ==========================================================
	// Telemetry arithmetic
	logic        [26:0] vin_prod;
	logic signed [17:0] vin_corr;
	logic        [10:0] vin_mant;
	logic signed [27:0] iout_prod;
	logic signed [17:0] iout_corr;
	logic signed [11:0] temp_delta;
	logic signed [29:0] iout_tc_prod;
	logic signed [17:0] iout_comp;
	logic        [10:0] iout_mant;
	logic        [15:0] vin_reading;
	logic        [15:0] iout_reading;
	logic        [15:0] temp_reading;

	assign vin_prod = vin_adc * cal.vin_gain;
	assign vin_corr = $signed({4'h0, vin_prod[26:GAIN_SHIFT]}) +
		$signed({{7{cal.vin_offset[10]}}, cal.vin_offset});
	// Clamp keeps the mantissa top bit clear
	assign vin_mant = (vin_corr < 18'sh00000) ? MANT_ZERO :
		(vin_corr > MANT_MAX_S) ? MANT_MAX : vin_corr[10:0];

	assign iout_prod = iout_adc * $signed({1'b0, cal.iout_gain});
	assign iout_corr = 18'(iout_prod >>> GAIN_SHIFT) +
		$signed({{7{cal.iout_offset[10]}}, cal.iout_offset});
	// Sense winding resistance rises with heat, so scale the excess back out
	assign temp_delta   = $signed({temp_adc[10], temp_adc}) - TEMP_REF_CNT;
	assign iout_tc_prod = iout_corr * temp_delta;
	assign iout_comp    = iout_corr - 18'(iout_tc_prod >>> TC_SHIFT);
	// Negative (sinking) values fall below the blank limit as well
	assign iout_mant = (iout_comp < IOUT_BLANK_CNT) ? MANT_ZERO :
		(iout_comp > MANT_MAX_S) ? MANT_MAX : iout_comp[10:0];

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			vin_reading  <= {EXP_VIN, MANT_ZERO};
			iout_reading <= {EXP_IOUT, MANT_ZERO};
			temp_reading <= {EXP_TEMP, MANT_ZERO};
		end
		else
		begin
			vin_reading  <= {EXP_VIN, vin_mant};
			iout_reading <= {EXP_IOUT, iout_mant};
			temp_reading <= {EXP_TEMP, temp_adc};
		end
	end

	// ==========================================================
	// Latched status flags
	logic [NUM_FLAGS-1:0] flags;
	logic [NUM_FLAGS-1:0] flag_set;
	logic                 evt_cmd;
	logic                 evt_data;
	logic                 evt_pec;
	logic                 clear_req;
	logic                 unit_off;
	logic                 pg_bad;

	assign flag_set = {evt_pec, evt_data, evt_cmd, cond.ot_warn, cond.ot, cond.vin_low_off,
		cond.vin_uv, cond.vin_ov, cond.iout_oc_warn, cond.iout_oc, cond.vout_ov};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++)
		begin : g_flag
			// Setting wins over a clear in the same cycle
			always_ff @(posedge core_clk)
			begin
				if (rst)
					flags[gi] <= 1'b0;
				else
					flags[gi] <= flag_set[gi] | (flags[gi] & ~clear_req);
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			unit_off <= 1'b0;
			pg_bad   <= 1'b0;
		end
		else
		begin
			unit_off <= cond.unit_off;
			pg_bad   <= ~cond.power_good;
		end
	end

	// ==========================================================
	// Status bytes and summary word
	logic [7:0]  vout_status;
	logic [7:0]  iout_status;
	logic [7:0]  input_status;
	logic [7:0]  temp_status;
	logic [7:0]  comm_status;
	logic [15:0] status_word;

	always_comb
	begin
		vout_status  = STATUS_BYTE_RST;
		iout_status  = STATUS_BYTE_RST;
		input_status = STATUS_BYTE_RST;
		temp_status  = STATUS_BYTE_RST;
		comm_status  = STATUS_BYTE_RST;
		status_word  = STATUS_WORD_RST;
		vout_status[BIT_FAULT]    = flags[FLG_VOUT_OV];
		iout_status[BIT_FAULT]    = flags[FLG_IOUT_OC];
		iout_status[BIT_IO_WARN]  = flags[FLG_IOUT_WARN];
		input_status[BIT_FAULT]   = flags[FLG_VIN_OV];
		input_status[BIT_IN_UV]   = flags[FLG_VIN_UV];
		input_status[BIT_IN_OFF]  = flags[FLG_VIN_OFF];
		temp_status[BIT_FAULT]    = flags[FLG_OT];
		temp_status[BIT_OT_WARN]  = flags[FLG_OT_WARN];
		comm_status[BIT_FAULT]    = flags[FLG_CML_CMD];
		comm_status[BIT_CML_DAT]  = flags[FLG_CML_DATA];
		comm_status[BIT_CML_PEC]  = flags[FLG_CML_PEC];
		status_word[STW_VOUT]     = |vout_status;
		status_word[STW_IOUT]     = |iout_status;
		status_word[STW_INPUT]    = |input_status;
		status_word[STW_PG_N]     = pg_bad;
		status_word[STW_OFF]      = unit_off;
		status_word[STW_VOUT_OV]  = vout_status[BIT_FAULT];
		status_word[STW_IOUT_OC]  = iout_status[BIT_FAULT];
		status_word[STW_VIN_UV]   = input_status[BIT_IN_UV];
		status_word[STW_TEMP]     = |temp_status;
		status_word[STW_CML]      = |comm_status;
	end

	// ==========================================================
	// Read data selection
	pmt_state_type state;
	logic [7:0]    cmd;
	logic [15:0]   tx_word;
	logic [1:0]    tx_idx;
	logic [7:0]    crc;

	wire [15:0] rd_word =
		(cmd == CMD_READ_VIN)     ? vin_reading :
		(cmd == CMD_OUTPUT_CURRENT_READING)    ? iout_reading :
		(cmd == CMD_READ_TEMP)    ? temp_reading :
		(cmd == CMD_STATUS_WORD)  ? status_word :
		(cmd == CMD_VIN_OFFSET)   ? {EXP_VIN, cal.vin_offset} :
		(cmd == CMD_VIN_GAIN)     ? cal.vin_gain :
		(cmd == CMD_IOUT_OFFSET)  ? {EXP_IOUT, cal.iout_offset} :
		(cmd == CMD_IOUT_GAIN)    ? cal.iout_gain :
		(cmd == CMD_OUTPUT_VOLTAGE_STATUS)  ? {8'h00, vout_status} :
		(cmd == CMD_OUTPUT_CURRENT_STATUS)  ? {8'h00, iout_status} :
		(cmd == CMD_STATUS_INPUT) ? {8'h00, input_status} :
		(cmd == CMD_STATUS_TEMP)  ? {8'h00, temp_status} :
		(cmd == CMD_STATUS_COMM)  ? {8'h00, comm_status} : {IDLE_BYTE, IDLE_BYTE};

	wire [1:0] tx_len = is_word_cmd(cmd) ? 2'h2 : is_byte_cmd(cmd) ? 2'h1 : 2'h0;
	// Unknown commands read all ones with no check byte
	wire [7:0] cur_tx_byte =
		(tx_len == 2'h0)    ? IDLE_BYTE :
		(tx_idx < tx_len)   ? ((tx_idx == 2'h0) ? tx_word[7:0] : tx_word[15:8]) :
		(tx_idx == tx_len)  ? crc : IDLE_BYTE;

	// ==========================================================
	// Bus slave state machine
	logic [2:0]    bit_cnt;
	logic [7:0]    shreg;
	logic          rd_mode;
	logic [1:0]    rx_cnt;
	logic          ack_phase;
	logic          pec_match;
	pmt_state_type next_state;
	logic [2:0]    next_bit_cnt;
	logic [7:0]    next_shreg;
	logic          next_rd_mode;
	logic [1:0]    next_rx_cnt;
	logic [7:0]    next_cmd;
	logic [15:0]   next_tx_word;
	logic [1:0]    next_tx_idx;
	logic [7:0]    next_crc;
	logic          next_ack_phase;
	logic          next_pec_match;
	logic          next_sda_oe_n;
	logic          next_evt_cmd;
	logic          next_evt_data;
	logic          next_evt_pec;
	logic          next_clear_req;

	wire [7:0] rx_byte = {shreg[6:0], sda_sync};
	wire       load_tx = scl_fall & ((state == ST_TXLOAD) |
		((state == ST_ACK) & ack_phase & rd_mode));

	always_comb
	begin
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_rd_mode   = rd_mode;
		next_rx_cnt    = rx_cnt;
		next_cmd       = cmd;
		next_tx_word   = tx_word;
		next_tx_idx    = tx_idx;
		next_crc       = crc;
		next_ack_phase = ack_phase;
		next_pec_match = pec_match;
		next_sda_oe_n  = sda_oe_n;
		next_evt_cmd   = 1'b0;
		next_evt_data  = 1'b0;
		next_evt_pec   = 1'b0;
		next_clear_req = 1'b0;
		if (bus_stop)
		begin
			next_state    = ST_IDLE;
			next_sda_oe_n = 1'b1;
			next_rd_mode  = 1'b0;
			next_rx_cnt   = 2'h0;
			if (!rd_mode)
			begin
				if (rx_cnt == 2'h1)
					next_clear_req = (cmd == CMD_CLEAR_FAULTS);
				else if (rx_cnt == 2'h2)
				begin
					next_clear_req = pec_match & (cmd == CMD_CLEAR_FAULTS);
					next_evt_pec   = ~pec_match & (cmd == CMD_CLEAR_FAULTS);
					next_evt_data  = ~pec_match & (cmd != CMD_CLEAR_FAULTS);
				end
				else if (rx_cnt == 2'h3)
					next_evt_data = 1'b1;
			end
		end
		else if (bus_start)
		begin
			next_state     = ST_ADDR;
			next_bit_cnt   = 3'h0;
			next_ack_phase = 1'b0;
			next_sda_oe_n  = 1'b1;
			if (state == ST_IDLE)
			begin
				next_crc     = CRC_INIT;
				next_rx_cnt  = 2'h0;
				next_rd_mode = 1'b0;
			end
		end
		else if (load_tx)
		begin
			next_state     = ST_TX;
			next_bit_cnt   = 3'h0;
			next_ack_phase = 1'b0;
			next_sda_oe_n  = cur_tx_byte[7];
			next_shreg     = {cur_tx_byte[6:0], 1'b1};
			next_crc       = crc8_step(crc, cur_tx_byte);
		end
		else if (scl_rise)
		begin
			case (state)
				ST_ADDR, ST_RX:
				begin
					next_shreg   = rx_byte;
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
					begin
						next_state = ST_ACK;
						next_crc   = crc8_step(crc, rx_byte);
						if (state == ST_ADDR)
						begin
							next_rd_mode = rx_byte[0];
							next_tx_idx  = 2'h0;
							next_tx_word = rd_word;
							if (rx_byte[7:1] != BUS_ADDR)
								next_state = ST_IDLE;
						end
						else
						begin
							if (rx_cnt != 2'h3)
								next_rx_cnt = rx_cnt + 2'h1;
							if (rx_cnt == 2'h0)
							begin
								next_cmd     = rx_byte;
								next_evt_cmd = ~(is_word_cmd(rx_byte) | is_byte_cmd(rx_byte) |
									(rx_byte == CMD_CLEAR_FAULTS));
							end
							if (rx_cnt == 2'h1)
								next_pec_match = (rx_byte == crc);
						end
					end
				end
				ST_TX:
				begin
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
						next_state = ST_MACK;
				end
				ST_MACK:
				begin
					// Host acknowledge asks for another byte
					if (!sda_sync)
					begin
						next_state  = ST_TXLOAD;
						next_tx_idx = (tx_idx == 2'h3) ? tx_idx : tx_idx + 2'h1;
					end
					else
						next_state = ST_IDLE;
				end
				default:
				begin
				end
			endcase
		end
		else if (scl_fall)
		begin
			case (state)
				ST_ACK:
				begin
					next_ack_phase = ~ack_phase;
					next_sda_oe_n  = ack_phase;
					if (ack_phase)
					begin
						next_state   = ST_RX;
						next_bit_cnt = 3'h0;
					end
				end
				ST_TX:
				begin
					next_sda_oe_n = shreg[7];
					next_shreg    = {shreg[6:0], 1'b1};
				end
				ST_MACK:
					next_sda_oe_n = 1'b1;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state     <= ST_IDLE;
			bit_cnt   <= 3'h0;
			shreg     <= 8'h00;
			rd_mode   <= 1'b0;
			rx_cnt    <= 2'h0;
			cmd       <= 8'h00;
			tx_word   <= 16'h0000;
			tx_idx    <= 2'h0;
			crc       <= CRC_INIT;
			ack_phase <= 1'b0;
			pec_match <= 1'b0;
			sda_oe_n  <= 1'b1;
			sda_out   <= 1'b0;
			evt_cmd   <= 1'b0;
			evt_data  <= 1'b0;
			evt_pec   <= 1'b0;
			clear_req <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			shreg     <= next_shreg;
			rd_mode   <= next_rd_mode;
			rx_cnt    <= next_rx_cnt;
			cmd       <= next_cmd;
			tx_word   <= next_tx_word;
			tx_idx    <= next_tx_idx;
			crc       <= next_crc;
			ack_phase <= next_ack_phase;
			pec_match <= next_pec_match;
			sda_oe_n  <= next_sda_oe_n;
			sda_out   <= 1'b0;
			evt_cmd   <= next_evt_cmd;
			evt_data  <= next_evt_data;
			evt_pec   <= next_evt_pec;
			clear_req <= next_clear_req;
		end
	end

endmodule

//--- pmt_telemetry_status_sva.sv
// Pin-level checker for the telemetry and status block
`timescale 1ns/1ns
module pmt_telemetry_status_sva
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n
);
	// ============================================================
	// Bus pin relations
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_sda_out_low: assert property (sda_out == 1'b0)
		else $error("data pin output value not low");
	a_reset_release: assert property (disable iff (1'b0) rst |=> sda_oe_n)
		else $error("data pin driven after reset");
	a_reset_hold: assert property (disable iff (1'b0) rst [*2] |-> sda_oe_n)
		else $error("data pin driven during reset");
	a_drive_scl_low: assert property ($fell(sda_oe_n) |-> !$past(scl_in))
		else $error("data pin driven while bus clock high");
	a_stable_scl_high: assert property (scl_in [*4] |-> $stable(sda_oe_n))
		else $error("data pin changed while bus clock high");
	a_idle_released: assert property (scl_in [*8] |-> sda_oe_n)
		else $error("data pin held with bus clock idle");
	a_start_release: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> sda_oe_n)
		else $error("data pin driven at a start");
	a_late_response: assert property ($fell(scl_in) |=> $stable(sda_oe_n))
		else $error("data pin changed before synchroniser delay");

	c_start: cover property (scl_in && $past(scl_in) && $fell(sda_in));
	c_drive: cover property ($fell(sda_oe_n));
	c_stop: cover property (scl_in && $rose(sda_in));
endmodule

//--- pmt_host_model.sv
// Bus host model clocking reads and writes on the two-wire bus
`timescale 1ns/1ns
module pmt_host_model
(
	input  wire logic core_clk,
	input  wire logic sda_wire,
	output logic      scl_pin,
	output logic      sda_oe_n
);
	// ============================================================
	// Bit and frame timing, 8 core cycles per bus clock
	initial
	begin
		scl_pin = 1'b1;
		sda_oe_n = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Data moves only while the clock is low; clock is idle high between frames
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n <= b;
		tick(2);
		scl_pin <= 1'b1;
		tick(2);
		r = sda_wire;
		tick(2);
		scl_pin <= 1'b0;
		tick(2);
	endtask

	task automatic start_cond;
		sda_oe_n <= 1'b1;
		tick(2);
		scl_pin <= 1'b1;
		tick(4);
		sda_oe_n <= 1'b0;
		tick(4);
		scl_pin <= 1'b0;
		tick(2);
	endtask

	task automatic stop_cond;
		sda_oe_n <= 1'b0;
		tick(2);
		scl_pin <= 1'b1;
		tick(4);
		sda_oe_n <= 1'b1;
		tick(4);
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask

	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask

	// Sends the low n bytes of v, most significant first
	task automatic write_seq(input logic [6:0] a, input logic [23:0] v, input int n,
		output logic ack);
		logic r;
		start_cond();
		put_byte({a, 1'b0}, ack);
		for (int i = n - 1; i >= 0; i--)
			put_byte(v[8*i +: 8], r);
		stop_cond();
	endtask

	// Low byte arrives first; the last byte is answered with a not-acknowledge
	task automatic read_seq(input logic [6:0] a, input logic [7:0] c, input int n,
		output logic [15:0] d);
		logic       r;
		logic [7:0] b;
		d = 16'h0000;
		start_cond();
		put_byte({a, 1'b0}, r);
		put_byte(c, r);
		start_cond();
		put_byte({a, 1'b1}, r);
		for (int i = 0; i < n; i++)
		begin
			get_byte(i == n - 1, b);
			d[8*i +: 8] = b;
		end
		stop_cond();
	endtask
endmodule

//--- pmt_telemetry_status_tb.sv
// Self-checking bench for the telemetry and status block
`timescale 1ns/1ns
module pmt_telemetry_status_tb
	import pmt_pkg::*;
;
	// ============================================================
	// Signals and instances
	localparam int MAX_CYCLES = 90000;
	logic               core_clk = 1'b0;
	logic               rst = 1'b1;
	logic               scl_pin;
	logic               h_oe_n;
	logic               sda_out;
	logic               sda_oe_n;
	wire                sda_wire = (sda_oe_n === 1'b0) ? 1'b0 : h_oe_n;
	logic        [10:0] vin_adc = 11'h000;
	logic signed [10:0] iout_adc = 11'h000;
	logic signed [10:0] temp_adc = 11'h064;
	pmt_cal_type        cal = '0;
	pmt_cond_type       cond = 10'h001;
	int                 miscompares = 0;
	int                 n_compared = 0;
	int                 cycles = 0;
	int                 seed = 32'hAEE61BA6;
	logic               ack;
	logic        [7:0]  pec_exp;
	logic        [15:0] st_word [10] = '{16'h8020, 16'h4010, 16'h4000, 16'h2000, 16'h2008,
		16'h2000, 16'h0004, 16'h0004, 16'h0040, 16'h0800};
	logic        [7:0]  st_cmd [10] = '{8'h7A, 8'h7B, 8'h7B, 8'h7C, 8'h7C, 8'h7C, 8'h7D,
		8'h7D, 8'h7E, 8'h7E};
	logic        [7:0]  st_byte [10] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h10, 8'h08, 8'h80,
		8'h40, 8'h00, 8'h00};

	always #20 core_clk = ~core_clk;

	pmt_telemetry_status i_dut (.core_clk(core_clk), .rst(rst), .scl_in(scl_pin),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .vin_adc(vin_adc),
		.iout_adc(iout_adc), .temp_adc(temp_adc), .cal(cal), .cond(cond));
	pmt_host_model i_host (.core_clk(core_clk), .sda_wire(sda_wire), .scl_pin(scl_pin),
		.sda_oe_n(h_oe_n));

	// ============================================================
	// Checking, reference model and closing
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] c, input int n, input logic [15:0] exp);
		logic [15:0] v;
		i_host.read_seq(BUS_ADDR, c, n, v);
		check(v, exp);
	endtask

	task automatic wr(input logic [23:0] v, input int n);
		i_host.write_seq(BUS_ADDR, v, n, ack);
	endtask

	function automatic logic [7:0] crc8(input logic [23:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	function automatic logic [15:0] vin_word();
		int v;
		v = ((int'(vin_adc) * int'(cal.vin_gain)) >>> 13) + int'($signed(cal.vin_offset));
		v = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
		return {EXP_VIN, 11'(v)};
	endfunction

	// Counts of 62.5 mA below 1.65 A, and any sinking current, read as zero
	function automatic logic [15:0] iout_word();
		int c;
		c = ((int'(iout_adc) * int'(cal.iout_gain)) >>> 13) + int'($signed(cal.iout_offset));
		c = c - ((c * (int'(temp_adc) - 100)) >>> 8);
		c = (c * 625 < 16500) ? 0 : (c > 1023) ? 1023 : c;
		return {EXP_IOUT, 11'(c)};
	endfunction

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYCLES)
		begin
			miscompares++;
			finish_test();
		end
	end

	// ============================================================
	// Scenarios
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		repeat (10) @(posedge core_clk);
		check({15'h0000, sda_oe_n}, 16'h0001);
		for (int i = 0; i < 6; i++)
			rd(CMD_STATUS_WORD + 8'(i), (i == 0) ? 2 : 1, 16'h0000);
		i_host.write_seq(BUS_ADDR + 7'h01, 24'h000079, 1, ack);
		check({15'h0000, ack}, 16'h0001);
		$display("test reset and address done");
		for (int k = 0; k < 8; k++)
		begin
			if (k < 3)
			begin
				cal <= {11'h000, 16'h2000, 11'h000, 16'h2000};
				iout_adc <= (k == 0) ? 11'h01A : (k == 1) ? 11'h01B : 11'h7FB;
				temp_adc <= 11'h064;
			end
			else
			begin
				cal.vin_offset <= 11'($random(seed) % 9);
				cal.vin_gain <= 16'h1E00 + 16'($random(seed) & 16'h03FF);
				cal.iout_offset <= 11'($random(seed) % 9);
				cal.iout_gain <= 16'h1E00 + 16'($random(seed) & 16'h03FF);
				iout_adc <= 11'($random(seed) % 700);
				temp_adc <= 11'(60 + ($random(seed) & 63));
			end
			vin_adc <= 11'($random(seed));
			repeat (2) @(posedge core_clk);
			rd(CMD_READ_VIN, 2, vin_word());
			rd(CMD_OUTPUT_CURRENT_READING, 2, iout_word());
			rd(CMD_READ_TEMP, 2, {EXP_TEMP, temp_adc});
			rd(CMD_VIN_OFFSET, 2, {EXP_VIN, cal.vin_offset});
			rd(CMD_VIN_GAIN, 2, cal.vin_gain);
			rd(CMD_IOUT_OFFSET, 2, {EXP_IOUT, cal.iout_offset});
			rd(CMD_IOUT_GAIN, 2, cal.iout_gain);
		end
		$display("test telemetry done");
		// Latched conditions pulse for 4 cycles and must outlive them; unit off and power good are held through the reads
		for (int i = 0; i < 10; i++)
		begin
			cond <= 10'h001 ^ (10'h200 >> i);
			repeat (4) @(posedge core_clk);
			if (i < 8)
				cond <= 10'h001;
			repeat (2) @(posedge core_clk);
			rd(CMD_STATUS_WORD, 2, st_word[i]);
			rd(st_cmd[i], 1, {8'h00, st_byte[i]});
			cond <= 10'h001;
			wr(24'h000003, 1);
			rd(CMD_STATUS_WORD, 2, 16'h0000);
		end
		$display("test status flags done");
		wr(24'h0000B7, 1);
		rd(8'hB7, 2, 16'hFFFF);
		rd(CMD_STATUS_WORD, 2, 16'h0002);
		wr({8'h00, CMD_CLEAR_FAULTS, crc8({8'h00, BUS_ADDR, 1'b0, CMD_CLEAR_FAULTS}) ^ 8'h01}, 2);
		rd(CMD_STATUS_COMM, 1, 16'h00A0);
		wr({8'h00, CMD_CLEAR_FAULTS, crc8({8'h00, BUS_ADDR, 1'b0, CMD_CLEAR_FAULTS})}, 2);
		rd(CMD_STATUS_COMM, 1, 16'h0000);
		wr({8'h00, CMD_STATUS_WORD, crc8({8'h00, BUS_ADDR, 1'b0, CMD_STATUS_WORD}) ^ 8'h01}, 2);
		rd(CMD_STATUS_COMM, 1, 16'h0040);
		wr(24'h000003, 1);
		wr(24'h03AA55, 3);
		rd(CMD_STATUS_COMM, 1, 16'h0040);
		// Check byte after a status byte covers both address bytes, the command and the data
		pec_exp = crc8({16'h0000, crc8({BUS_ADDR, 1'b0, CMD_STATUS_COMM, BUS_ADDR, 1'b1}) ^ 8'h40});
		rd(CMD_STATUS_COMM, 2, {pec_exp, 8'h40});
		$display("test communication faults done");
		finish_test();
	end
endmodule

bind pmt_telemetry_status pmt_telemetry_status_sva i_sva (.core_clk(core_clk), .rst(rst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
